// ===== hdl/dma_request_screening.sv
// Purpose: Screens each DMA request and gives one disposition per page piece
// Assumes: Translation walk sits outside, reached over the xreq/xlat ports
// Notes: One request in flight; a new one is taken only once all pieces are answered
`timescale 1ns/10ps
module dma_request_screening (
  input wire logic clk,
  input wire logic rstn,
  screen_if.screener link,
  output logic tiny_read_flag,
  output logic xreq_valid,
  output screen_pkg::at_t xreq_at,
  output screen_pkg::kind_t xreq_kind,
  output logic [screen_pkg::ADDR_W-1:0] xreq_addr,
  output logic [screen_pkg::LEN_W-1:0] xreq_len,
  output logic xreq_pasid_en,
  output logic [screen_pkg::PASID_W-1:0] xreq_pasid,
  output logic [screen_pkg::SRC_W-1:0] xreq_src,
  input wire logic xlat_done,
  input wire logic [screen_pkg::ADDR_W-1:0] xlat_addr,
  input wire logic xlat_fault,
  input wire logic [screen_pkg::CODE_W-1:0] xlat_code,
  input wire logic xlat_read_only,
  input wire logic xlat_pass_through,
  input wire logic xlat_first_stage
);
  import screen_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EVAL = 2'b01,
    S_XLAT = 2'b11,
    S_RESP = 2'b10
  } scr_state_t;

  typedef struct packed {
    scr_state_t st;
    at_t at;
    kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] remain;
    logic [LEN_W-1:0] piece;
    logic [BE_W-1:0] fbe;
    logic pasid_en;
    logic [PASID_W-1:0] pasid;
    logic [SRC_W-1:0] src;
    disp_t disp;
    logic [CODE_W-1:0] code;
    logic [ADDR_W-1:0] out_addr;
    logic obf;
    logic tiny;
  } scr_t;

  scr_t s_q;
  scr_t s_d;
  logic [LEN_W-1:0] rem_next;
  logic win;
  // Decodes for the judging states: xlat_win for S_XLAT, the piece classes for S_EVAL
  logic xlat_win;
  logic tiny_now;
  logic one_write;

  // Capability is fixed: the permissive tiny-read handling below is always built
  assign tiny_read_flag = TINY_READ_CAP;

  // Handshakes straight from state, data from the registered request
  assign link.req_ready = (s_q.st == S_IDLE);
  assign link.rsp_valid = (s_q.st == S_RESP);
  assign link.rsp_disp = s_q.disp;
  assign link.rsp_code = s_q.code;
  assign link.rsp_addr = s_q.out_addr;
  assign link.rsp_len = s_q.piece;
  assign link.rsp_obf = s_q.obf;
  assign link.rsp_src = s_q.src;

  // Walk request, held steady until xlat_done
  assign xreq_valid = (s_q.st == S_XLAT);
  assign xreq_at = s_q.at;
  assign xreq_kind = s_q.kind;
  assign xreq_addr = s_q.addr;
  assign xreq_len = s_q.piece;
  assign xreq_pasid_en = s_q.pasid_en;
  assign xreq_pasid = s_q.pasid;
  assign xreq_src = s_q.src;

  // Length left after this piece, and window hits of the input and the walked address
  assign rem_next = s_q.remain - s_q.piece;
  assign win = in_intr_win(s_q.addr);
  assign xlat_win = in_intr_win(xlat_addr);

  // Classes of the piece being judged; later pieces carry BE_ALL, so only a first piece can be tiny
  assign tiny_now = (s_q.kind == K_READ) && (s_q.remain == LEN_ONE) && (s_q.fbe == BE_NONE);
  assign one_write = (s_q.kind == K_WRITE) && (s_q.remain == LEN_ONE);

  // Next-state logic for the whole screening stage
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      S_IDLE: begin
        // The state register is the only buffer, so a request is taken only while idle
        if (link.req_valid) begin
          s_d.at = link.req_at;
          s_d.kind = link.req_kind;
          s_d.addr = link.req_addr;
          s_d.remain = link.req_len;
          s_d.fbe = link.req_first_be;
          s_d.pasid_en = link.req_pasid_en;
          s_d.pasid = link.req_pasid;
          s_d.src = link.req_src;
          s_d.st = S_EVAL;
        end
      end
      S_EVAL: begin
        // Each piece stays inside one page and is judged on its own
        s_d.piece = page_piece(s_q.addr, s_q.remain);
        s_d.tiny = tiny_now;
        s_d.obf = 1'b0;
        s_d.code = CODE_NONE;
        s_d.out_addr = s_q.addr;
        s_d.disp = DISP_FWD;
        s_d.st = S_RESP;
        if (s_q.at == AT_TRANS) begin
          // Already translated: pass on, unless it lands in the window
          if (win) begin
            s_d.disp = DISP_BLOCK;
            s_d.code = CODE_UR;
          end
        end else if (!s_q.pasid_en && win) begin
          // Non-PASID window requests never reach the walk
          if (one_write) begin
            s_d.disp = DISP_INTR;
          end else if (tiny_now) begin
            s_d.disp = DISP_DONE;
            s_d.obf = 1'b1;
          end else begin
            s_d.disp = DISP_BLOCK;
            s_d.code = CODE_INTR_WIN;
          end
        end else begin
          // PASID window requests walk the tables like any other
          s_d.st = S_XLAT;
        end
      end
      S_XLAT: begin
        // Walk results count only in the cycle in which xlat_done is high
        if (xlat_done) begin
          s_d.out_addr = xlat_addr;
          s_d.st = S_RESP;
          if (xlat_fault) begin
            // Missing read permission alone does not fault a tiny read
            if (TINY_READ_CAP && s_q.tiny && xlat_read_only) begin
              s_d.disp = DISP_DONE;
              s_d.obf = 1'b1;
            end else begin
              s_d.disp = DISP_BLOCK;
              s_d.code = xlat_code;
            end
          end else if (s_q.pasid_en && xlat_pass_through && win) begin
            // Pass-through would hand a window address on untranslated
            s_d.disp = DISP_BLOCK;
            s_d.code = CODE_PT_WIN;
          end else if (s_q.at != AT_TRANS && xlat_win) begin
            s_d.disp = DISP_BLOCK;
            s_d.code = xlat_first_stage ? CODE_FS_WIN : CODE_SS_WIN;
          end else begin
            // Tiny reads that translate go on with every byte enable off
            s_d.disp = DISP_FWD;
          end
        end
      end
      S_RESP: begin
        // Piece accepted: step past it, the address moving by the piece in bytes
        if (link.rsp_ready) begin
          s_d.remain = rem_next;
          s_d.addr = s_q.addr + {{(ADDR_W-LEN_W-2){1'b0}}, s_q.piece, 2'b00};
          s_d.fbe = BE_ALL;
          s_d.st = (rem_next == LEN_ZERO) ? S_IDLE : S_EVAL;
        end
      end
    endcase
  end

  // Single state register; reset gives an idle stage with nothing pending
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== hdl/screen_pkg.sv
// Purpose: Shared types and constants for the DMA request screening link
// Assumes: 64-bit addresses, lengths counted in doublewords (1..1024)
// Notes: Interrupt window is the 1 MB region whose address bits 63:20 match INTR_WIN
package screen_pkg;
  localparam int ADDR_W = 64;
  localparam int LEN_W = 11;
  localparam int SRC_W = 16;
  localparam int PASID_W = 20;
  localparam int CODE_W = 8;
  localparam int FUNC_W = 8;
  localparam int BE_W = 4;
  localparam int PAGE_SHIFT = 12;
  localparam int WIN_SHIFT = 20;
  localparam logic [LEN_W-1:0] DW_PER_PAGE = 11'h400;
  localparam logic [LEN_W-1:0] LEN_ONE = 11'h001;
  localparam logic [LEN_W-1:0] LEN_ZERO = 11'h000;
  localparam logic [ADDR_W-WIN_SHIFT-1:0] INTR_WIN = 44'h000_0000_0FEE;
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [7:0] DEVFN_ZERO = 8'h00;
  localparam logic TINY_READ_CAP = 1'b1;

  // Condition codes reported with a blocked request
  localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
  localparam logic [CODE_W-1:0] CODE_INTR_WIN = 8'h01;
  localparam logic [CODE_W-1:0] CODE_PT_WIN = 8'h02;
  localparam logic [CODE_W-1:0] CODE_FS_WIN = 8'h04;
  localparam logic [CODE_W-1:0] CODE_SS_WIN = 8'h08;
  localparam logic [CODE_W-1:0] CODE_UR = 8'h10;

  typedef enum logic [1:0] {
    AT_UNTRANS = 2'h0,
    AT_XREQ = 2'h1,
    AT_TRANS = 2'h2
  } at_t;

  typedef enum logic [1:0] {
    K_READ = 2'h0,
    K_WRITE = 2'h1,
    K_ATOMIC = 2'h2
  } kind_t;

  typedef enum logic [1:0] {
    DISP_FWD = 2'h0,
    DISP_INTR = 2'h1,
    DISP_DONE = 2'h2,
    DISP_BLOCK = 2'h3
  } disp_t;

  typedef enum logic [1:0] {
    SRC_NATIVE = 2'h0,
    SRC_BRIDGE_OWN = 2'h1,
    SRC_CONV = 2'h2
  } src_mode_t;

  // Doublewords left before the next 4 KB boundary, capped at the request length
  function automatic logic [LEN_W-1:0] page_piece(input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n);
    logic [LEN_W-1:0] room;
    room = DW_PER_PAGE - {1'b0, a[PAGE_SHIFT-1:2]};
    return (n > room) ? room : n;
  endfunction

  function automatic logic in_intr_win(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:WIN_SHIFT] == INTR_WIN;
  endfunction
endpackage

// ===== hdl/screen_if.sv
// Purpose: Link between a DMA requester and the screening stage
// Assumes: Both ends share clk and rstn
// Notes: Valid/ready on both the request and the disposition channel
`timescale 1ns/10ps
interface screen_if;
  import screen_pkg::*;
  logic req_valid;
  logic req_ready;
  at_t req_at;
  kind_t req_kind;
  logic [ADDR_W-1:0] req_addr;
  logic [LEN_W-1:0] req_len;
  logic [BE_W-1:0] req_first_be;
  logic req_pasid_en;
  logic [PASID_W-1:0] req_pasid;
  logic [SRC_W-1:0] req_src;
  logic rsp_valid;
  logic rsp_ready;
  disp_t rsp_disp;
  logic [CODE_W-1:0] rsp_code;
  logic [ADDR_W-1:0] rsp_addr;
  logic [LEN_W-1:0] rsp_len;
  logic rsp_obf;
  logic [SRC_W-1:0] rsp_src;

  modport requester (
    output req_valid, req_at, req_kind, req_addr, req_len, req_first_be, req_pasid_en, req_pasid, req_src,
    output rsp_ready,
    input req_ready, rsp_valid, rsp_disp, rsp_code, rsp_addr, rsp_len, rsp_obf, rsp_src
  );

  modport screener (
    input req_valid, req_at, req_kind, req_addr, req_len, req_first_be, req_pasid_en, req_pasid, req_src,
    input rsp_ready,
    output req_ready, rsp_valid, rsp_disp, rsp_code, rsp_addr, rsp_len, rsp_obf, rsp_src
  );
endinterface

// ===== hdl/dma_requester.sv
// Purpose: Requester end: forms source identifier and PASID, splits at pages
// Assumes: Commands carry a length of 1 to 1024 doublewords
// Notes: Dispositions are handed to the user side unchanged
`timescale 1ns/10ps
module dma_requester (
  input wire logic clk,
  input wire logic rstn,
  screen_if.requester link,
  input wire screen_pkg::src_mode_t src_mode,
  input wire logic [screen_pkg::SRC_W-1:0] own_id,
  input wire logic [screen_pkg::SRC_W-1:0] bridge_id,
  input wire logic [7:0] sec_bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire screen_pkg::at_t cmd_at,
  input wire screen_pkg::kind_t cmd_kind,
  input wire logic [screen_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [screen_pkg::LEN_W-1:0] cmd_len,
  input wire logic [screen_pkg::BE_W-1:0] cmd_first_be,
  input wire logic [screen_pkg::FUNC_W-1:0] cmd_func,
  input wire logic cmd_slice_en,
  input wire logic [screen_pkg::PASID_W-1:0] cmd_slice_pasid,
  output logic usr_rsp_valid,
  input wire logic usr_rsp_ready,
  output screen_pkg::disp_t usr_rsp_disp,
  output logic [screen_pkg::CODE_W-1:0] usr_rsp_code,
  output logic [screen_pkg::ADDR_W-1:0] usr_rsp_addr,
  output logic [screen_pkg::LEN_W-1:0] usr_rsp_len,
  output logic usr_rsp_obf
);
  import screen_pkg::*;

  typedef enum logic {
    R_IDLE = 1'b0,
    R_SEND = 1'b1
  } req_state_t;

  typedef struct packed {
    req_state_t st;
    at_t at;
    kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] remain;
    logic [LEN_W-1:0] piece;
    logic [BE_W-1:0] fbe;
    logic pasid_en;
    logic [PASID_W-1:0] pasid;
    logic [SRC_W-1:0] src;
  } req_t;

  req_t r_q;
  req_t r_d;
  logic [LEN_W-1:0] rem_next;
  logic [ADDR_W-1:0] addr_next;

  assign cmd_ready = (r_q.st == R_IDLE);
  assign link.req_valid = (r_q.st == R_SEND);
  assign link.req_at = r_q.at;
  assign link.req_kind = r_q.kind;
  assign link.req_addr = r_q.addr;
  assign link.req_len = r_q.piece;
  assign link.req_first_be = r_q.fbe;
  assign link.req_pasid_en = r_q.pasid_en;
  assign link.req_pasid = r_q.pasid;
  assign link.req_src = r_q.src;

  // Dispositions already come from the screener's flops
  assign usr_rsp_valid = link.rsp_valid;
  assign link.rsp_ready = usr_rsp_ready;
  assign usr_rsp_disp = link.rsp_disp;
  assign usr_rsp_code = link.rsp_code;
  assign usr_rsp_addr = link.rsp_addr;
  assign usr_rsp_len = link.rsp_len;
  assign usr_rsp_obf = link.rsp_obf;

  assign rem_next = r_q.remain - r_q.piece;
  assign addr_next = r_q.addr + {{(ADDR_W-LEN_W-2){1'b0}}, r_q.piece, 2'b00};

  // Capture a command, then issue it page by page
  always_comb begin
    r_d = r_q;
    unique case (r_q.st)
      R_IDLE: begin
        if (cmd_valid) begin
          r_d.at = cmd_at;
          r_d.kind = cmd_kind;
          r_d.addr = cmd_addr;
          r_d.remain = cmd_len;
          r_d.piece = page_piece(cmd_addr, cmd_len);
          r_d.fbe = cmd_first_be;
          // Slices share the function's identifier, so PASID tells them apart
          r_d.pasid_en = cmd_slice_en;
          r_d.pasid = cmd_slice_pasid;
          unique case (src_mode)
            SRC_BRIDGE_OWN: r_d.src = {sec_bus, DEVFN_ZERO};
            SRC_CONV: r_d.src = bridge_id;
            default: r_d.src = own_id + {{(SRC_W-FUNC_W){1'b0}}, cmd_func};
          endcase
          r_d.st = R_SEND;
        end
      end
      R_SEND: begin
        if (link.req_ready) begin
          r_d.remain = rem_next;
          r_d.addr = addr_next;
          r_d.piece = page_piece(addr_next, rem_next);
          r_d.fbe = BE_ALL;
          r_d.st = (rem_next == LEN_ZERO) ? R_IDLE : R_SEND;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule

// ===== sim/dma_request_screening_sva.sv
// Purpose: Assertions on the requester to screener link
// Assumes: One clock domain, rstn active low and asynchronous
// Notes: Direct dispositions appear exactly two cycles after the take
`timescale 1ns/10ps
module dma_request_screening_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire screen_pkg::at_t req_at,
  input wire screen_pkg::kind_t req_kind,
  input wire logic [screen_pkg::ADDR_W-1:0] req_addr,
  input wire logic [screen_pkg::LEN_W-1:0] req_len,
  input wire logic [screen_pkg::BE_W-1:0] req_first_be,
  input wire logic req_pasid_en,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire screen_pkg::disp_t rsp_disp,
  input wire logic [screen_pkg::CODE_W-1:0] rsp_code,
  input wire logic rsp_obf
);
  import screen_pkg::*;
  logic take, win, dir, one_wr, tiny;
  // Decoded request classes, sampled at the take
  assign take = req_valid && req_ready;
  assign win = req_addr[ADDR_W-1:WIN_SHIFT] == INTR_WIN;
  assign dir = !req_pasid_en && req_at != AT_TRANS && win;
  assign one_wr = req_kind == K_WRITE && req_len == LEN_ONE;
  assign tiny = req_kind == K_READ && req_len == LEN_ONE && req_first_be == BE_NONE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_NO_CROSS: assert property (req_valid |-> ({2'b00, req_addr[PAGE_SHIFT-1:2]} + {1'b0, req_len}) <= {1'b0, DW_PER_PAGE})
    else $error("request piece crosses a page");
  AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_len))
    else $error("request changed before take");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_disp) && $stable(rsp_code))
    else $error("response changed before accept");
  AST_BUSY: assert property (take |=> !req_ready [*2])
    else $error("second request taken while busy");
  AST_INTR: assert property (take && dir && one_wr |-> ##2 rsp_valid && rsp_disp == DISP_INTR)
    else $error("window write not routed as interrupt");
  AST_TINY: assert property (take && dir && tiny |-> ##2 rsp_valid && rsp_disp == DISP_DONE && rsp_obf)
    else $error("window tiny read not completed obfuscated");
  AST_WIN_BLK: assert property (take && dir && !one_wr && !tiny |-> ##2 rsp_valid
    && rsp_disp == DISP_BLOCK && rsp_code == CODE_INTR_WIN)
    else $error("illegal window request not blocked");
  AST_UR: assert property (take && req_at == AT_TRANS && win |-> ##2 rsp_valid && rsp_disp == DISP_BLOCK && rsp_code == CODE_UR)
    else $error("translated window request not UR");
  AST_TRANS_FWD: assert property (take && req_at == AT_TRANS && !win |-> ##2 rsp_valid && rsp_disp == DISP_FWD)
    else $error("translated request not forwarded");
  AST_CODE_NONE: assert property (rsp_valid && rsp_disp != DISP_BLOCK |-> rsp_code == CODE_NONE)
    else $error("code set on unblocked response");

  // Main dispositions and a piece ending on the page edge
  C_INTR: cover property (rsp_valid && rsp_ready && rsp_disp == DISP_INTR);
  C_DONE: cover property (rsp_valid && rsp_ready && rsp_disp == DISP_DONE);
  C_BLOCK: cover property (rsp_valid && rsp_ready && rsp_disp == DISP_BLOCK);
  C_EDGE: cover property (take && ({2'b00, req_addr[PAGE_SHIFT-1:2]} + {1'b0, req_len}) == {1'b0, DW_PER_PAGE});
endmodule

// ===== sim/dma_request_screening_tb_top.sv
// Purpose: Self-checking bench joining requester and screener
// Assumes: Bench acts as command source, translation walk and response sink
// Notes: Expectations queued by the driver, popped by the response monitor
`timescale 1ns/10ps
module dma_request_screening_tb_top;
  import screen_pkg::*;
  typedef struct packed {disp_t d; logic [CODE_W-1:0] c; logic o; logic [LEN_W-1:0] l; logic [ADDR_W-1:0] a;} exp_t;
  localparam logic [ADDR_W-1:0] WA = 64'h0000_0000_FEE0_0000;
  localparam logic [ADDR_W-1:0] PA = 64'h0000_0000_2000_0000;
  logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_ready, cmd_slice_en = 1'b0, usr_rsp_valid;
  logic usr_rsp_ready = 1'b1, usr_rsp_obf, tiny_read_flag, xreq_valid, xlat_done = 1'b0, stall = 1'b0;
  logic xlat_fault = 1'b0, xlat_read_only = 1'b0, xlat_pass_through = 1'b0, xlat_first_stage = 1'b0, xreq_pasid_en;
  src_mode_t src_mode = SRC_NATIVE;
  logic [SRC_W-1:0] own_id = 16'h0100, bridge_id = 16'h0A08, exp_src = 16'h0103, xreq_src;
  logic [7:0] sec_bus = 8'h5A, f;
  at_t cmd_at = AT_UNTRANS, xreq_at, cur_at;
  kind_t cmd_kind = K_READ, xreq_kind, cur_kind;
  logic [ADDR_W-1:0] cmd_addr = '0, usr_rsp_addr, xlat_addr = '0, a, xreq_addr, cur_addr;
  logic [LEN_W-1:0] cmd_len = 11'h001, usr_rsp_len, xreq_len, cur_len;
  logic [BE_W-1:0] cmd_first_be = 4'hF;
  logic [FUNC_W-1:0] cmd_func = 8'h03;
  logic [PASID_W-1:0] cmd_slice_pasid = '0, xreq_pasid;
  logic [PASID_W:0] exp_pasid = '0;
  disp_t usr_rsp_disp;
  logic [CODE_W-1:0] usr_rsp_code, xlat_code = '0;
  exp_t expq[$];
  exp_t e;
  int miscompares = 0, n_tests = 0, cycles = 0, wcnt = 0, wdly = 0;

  screen_if screen_if_i();
  dma_requester dma_requester_i(.clk, .rstn, .link(screen_if_i), .src_mode, .own_id, .bridge_id, .sec_bus,
    .cmd_valid, .cmd_ready, .cmd_at, .cmd_kind, .cmd_addr, .cmd_len, .cmd_first_be, .cmd_func, .cmd_slice_en,
    .cmd_slice_pasid, .usr_rsp_valid, .usr_rsp_ready, .usr_rsp_disp, .usr_rsp_code, .usr_rsp_addr,
    .usr_rsp_len, .usr_rsp_obf);
  dma_request_screening dma_request_screening_i(.clk, .rstn, .link(screen_if_i), .tiny_read_flag,
    .xreq_valid, .xreq_at, .xreq_kind, .xreq_addr, .xreq_len, .xreq_pasid_en, .xreq_pasid,
    .xreq_src, .xlat_done, .xlat_addr, .xlat_fault, .xlat_code, .xlat_read_only, .xlat_pass_through,
    .xlat_first_stage);
  dma_request_screening_sva dma_request_screening_sva_i(.clk, .rstn, .req_valid(screen_if_i.req_valid),
    .req_ready(screen_if_i.req_ready), .req_at(screen_if_i.req_at), .req_kind(screen_if_i.req_kind),
    .req_addr(screen_if_i.req_addr), .req_len(screen_if_i.req_len), .req_first_be(screen_if_i.req_first_be),
    .req_pasid_en(screen_if_i.req_pasid_en), .rsp_valid(screen_if_i.rsp_valid),
    .rsp_ready(screen_if_i.rsp_ready), .rsp_disp(screen_if_i.rsp_disp), .rsp_code(screen_if_i.rsp_code),
    .rsp_obf(screen_if_i.rsp_obf));

  always #5 clk = ~clk;

  task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  // Walk model: answers after a random wait so slow walks are exercised too
  always @(posedge clk) begin
    if (xreq_valid && !xlat_done && wcnt >= wdly) begin
      xlat_done <= 1'b1;
      wcnt <= 0;
      check("xreq_at", xreq_at, cur_at);
      check("xreq_req", {xreq_kind, xreq_addr, xreq_len}, {cur_kind, cur_addr, cur_len});
      check("xreq_id", {xreq_src, xreq_pasid_en, xreq_pasid}, {exp_src, exp_pasid});
    end else begin
      xlat_done <= 1'b0;
      wcnt <= xreq_valid ? wcnt + 1 : 0;
    end
  end

  // Monitor: identifiers at each take, dispositions against the oldest note
  always @(posedge clk) begin
    usr_rsp_ready <= !(stall && cycles[0]);
    if (screen_if_i.req_valid && screen_if_i.req_ready) begin
      check("req_src", screen_if_i.req_src, exp_src);
      check("req_pasid", {screen_if_i.req_pasid_en, screen_if_i.req_pasid}, exp_pasid);
    end
    if (usr_rsp_valid && usr_rsp_ready) begin
      if (expq.size() == 0) begin
        check("rsp_extra", 1'b1, 1'b0);
      end else begin
        e = expq.pop_front();
        check("rsp", {usr_rsp_disp, usr_rsp_code, usr_rsp_obf, usr_rsp_len}, {e.d, e.c, e.o, e.l});
        if (e.a !== '1) check("rsp_addr", usr_rsp_addr, e.a);
        check("rsp_src", screen_if_i.rsp_src, exp_src);
      end
    end
  end

  // Hands one command over and waits for the requester to take it and for all its expected dispositions
  task automatic send(at_t at, kind_t k, logic [ADDR_W-1:0] ad, logic [LEN_W-1:0] n, logic [BE_W-1:0] be);
    cmd_at <= at;
    cmd_kind <= k;
    cmd_addr <= ad;
    cmd_len <= n;
    cmd_first_be <= be;
    cmd_valid <= 1'b1;
    cur_at = at;
    cur_kind = k;
    cur_addr = ad;
    cur_len = n;
    @(posedge clk);
    while (!cmd_ready) @(posedge clk);
    cmd_valid <= 1'b0;
    while (expq.size() != 0) @(posedge clk);
    $display("test done at cycle %0d", cycles);
  endtask

  // Single-piece request; w = {fault, read_only, pass_through, first_stage}; code FF means walk code
  task automatic one(at_t at, kind_t k, logic [ADDR_W-1:0] ad, logic [BE_W-1:0] be, logic [LEN_W-1:0] n,
                     logic [3:0] w, logic [ADDR_W-1:0] xa, disp_t d, logic [CODE_W-1:0] c, logic o);
    logic [CODE_W-1:0] r;
    r = 8'h40 | 8'($urandom % 64);
    {xlat_fault, xlat_read_only, xlat_pass_through, xlat_first_stage} <= w;
    xlat_addr <= xa;
    xlat_code <= r;
    wdly <= $urandom % 4;
    stall <= 1'($urandom % 2);
    expq.push_back('{d, (c == 8'hFF) ? r : c, o, n, (d == DISP_BLOCK) ? '1 : xa});
    send(at, k, ad, n, be);
  endtask

  initial begin
    void'($urandom(9));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("cap", tiny_read_flag, 1'b1);
    one(AT_UNTRANS, K_WRITE, WA, 4'hF, 11'h001, 4'h0, WA, DISP_INTR, CODE_NONE, 1'b0);
    one(AT_UNTRANS, K_READ, WA + 64'h40, 4'h0, 11'h001, 4'h0, WA + 64'h40, DISP_DONE, CODE_NONE, 1'b1);
    one(AT_UNTRANS, K_READ, WA, 4'hF, 11'h001, 4'h0, WA, DISP_BLOCK, CODE_INTR_WIN, 1'b0);
    one(AT_XREQ, K_ATOMIC, WA, 4'hF, 11'h001, 4'h0, WA, DISP_BLOCK, CODE_INTR_WIN, 1'b0);
    one(AT_UNTRANS, K_WRITE, WA, 4'hF, 11'h002, 4'h0, WA, DISP_BLOCK, CODE_INTR_WIN, 1'b0);
    one(AT_TRANS, K_READ, WA, 4'hF, 11'h001, 4'h0, WA, DISP_BLOCK, CODE_UR, 1'b0);
    one(AT_UNTRANS, K_READ, PA, 4'h0, 11'h001, 4'hC, PA, DISP_DONE, CODE_NONE, 1'b1);
    one(AT_UNTRANS, K_READ, PA, 4'h0, 11'h001, 4'h8, PA, DISP_BLOCK, 8'hFF, 1'b0);
    one(AT_UNTRANS, K_READ, PA, 4'h0, 11'h001, 4'h0, PA + 64'h1000, DISP_FWD, CODE_NONE, 1'b0);
    one(AT_UNTRANS, K_READ, PA, 4'hF, 11'h004, 4'hC, PA, DISP_BLOCK, 8'hFF, 1'b0);
    one(AT_UNTRANS, K_READ, PA, 4'hF, 11'h004, 4'h1, WA, DISP_BLOCK, CODE_FS_WIN, 1'b0);
    one(AT_XREQ, K_READ, PA, 4'hF, 11'h002, 4'h0, WA, DISP_BLOCK, CODE_SS_WIN, 1'b0);
    // Each source mode, with a fresh function number, over a page-crossing write
    for (int m = 0; m < 3; m++) begin
      f = 8'($urandom % 8);
      src_mode <= src_mode_t'(m);
      cmd_func <= f;
      exp_src = (m == 0) ? own_id + 16'(f) : (m == 1) ? {sec_bus, 8'h00} : bridge_id;
      a = {32'h0, 8'h12, 12'($urandom), 12'hFF8};
      expq.push_back('{DISP_FWD, CODE_NONE, 1'b0, 11'h002, a});
      expq.push_back('{DISP_FWD, CODE_NONE, 1'b0, 11'h003, a + 64'h8});
      send(AT_TRANS, K_WRITE, a, 11'h005, 4'hF);
    end
    // Slice traffic carries its PASID into the window
    cmd_slice_en <= 1'b1;
    cmd_slice_pasid <= 20'h1A5C3;
    exp_pasid = {1'b1, 20'h1A5C3};
    one(AT_UNTRANS, K_WRITE, WA, 4'hF, 11'h001, 4'h2, PA, DISP_BLOCK, CODE_PT_WIN, 1'b0);
    one(AT_UNTRANS, K_WRITE, WA, 4'hF, 11'h001, 4'h0, PA, DISP_FWD, CODE_NONE, 1'b0);
    end_of_test();
  end
endmodule
